/* File: common/b4_cfg.svh */
// Constants for the burst-of-four DDR static memory port
// Operation
// - Build as 1M x 36 or 2M x 18
// - Separate read and write data ports
// - Every access moves exactly four DDR beats
// - Commands sampled on rising positive clock only
// - Controller alternates read and write cycles
// - Beats 1,3 on positive, 2,4 negative
// - Byte enable low writes its beat byte
// - Write data starts one cycle after command
// - Write takes two full clock cycles
// - Read beats from third and fourth edges
// - Read latency is 2.0 cycles
// - Read takes two full clock cycles
// - Echo clocks run in step with data
// - Valid flag marks beats carrying read data
// - Low read select starts a read
// - Low write select starts a write
// - Valid flag changes on echo clock edges
// - DLL off: bypass, clear, one-cycle latency
`ifndef B4_CFG_SVH
`define B4_CFG_SVH

`define B4_BURST 4
`define B4_BYTE_W 9
`define B4_DATA_W 36
`define B4_ADDR_W 18
`define B4_RD_LAT_DLL 2
`define B4_RD_LAT_OFF 1
`define B4_CLK_NS 10
`define B4_DLL_LOCK_CYC 1024

`endif

/* File: common/b4_pkg.sv */
// Types for the two ends of the memory link: slot order at the controller, latency mode at the device
`default_nettype none
package b4_pkg;

  typedef enum logic [0:0] {
    B4_SLOT_RD = 1'b0,
    B4_SLOT_WR = 1'b1
  } b4_slot_e;

  typedef enum logic [0:0] {
    B4_LAT_FULL = 1'b0,
    B4_LAT_ONE = 1'b1
  } b4_lat_e;

endpackage
`default_nettype wire

/* File: common/b4_if.sv */
// Pin bundle between memory controller and memory device
`timescale 1ns/10ps
`default_nettype none
`include "b4_cfg.svh"
interface b4_if #(
  parameter int DATA_W = `B4_DATA_W,
  parameter int ADDR_W = `B4_ADDR_W
);
  localparam int BYTES = DATA_W / `B4_BYTE_W;

  logic k_pos;
  logic k_neg;
  logic read_select_n;
  logic write_select_n;
  logic [ADDR_W-1:0] sync_address_in;
  logic [DATA_W-1:0] d;
  logic [BYTES-1:0] byte_write_n;
  logic [DATA_W-1:0] q;
  logic echo_clock_pos;
  logic echo_clock_neg;
  logic read_valid_flag;
  logic dll_off_n;

  modport mem (
    input k_pos, k_neg, read_select_n, write_select_n, sync_address_in, d, byte_write_n,
    input dll_off_n,
    output q, echo_clock_pos, echo_clock_neg, read_valid_flag
  );

  modport ctrl (
    output k_pos, k_neg, read_select_n, write_select_n, sync_address_in, d, byte_write_n,
    output dll_off_n,
    input q, echo_clock_pos, echo_clock_neg, read_valid_flag
  );
endinterface
`default_nettype wire

/* File: hw/b4_sync.sv */
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/10ps
`default_nettype none
module b4_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in)
  begin
    meta_q <= d_in;
    q_out <= meta_q;
  end
endmodule
`default_nettype wire

/* File: hw/b4_mem_end.sv */
// Memory device end: DDR burst-of-four storage on the link clocks
`timescale 1ns/10ps
`default_nettype none
`include "b4_cfg.svh"
module b4_mem_end #(
  parameter int DATA_W = `B4_DATA_W,
  parameter int ADDR_W = `B4_ADDR_W,
  parameter int LOCK_CYC = `B4_DLL_LOCK_CYC
) (
  b4_if.mem link,
  input wire logic sys_rst_in,
  output logic dll_bypass_out,
  output logic dll_locked_out
);
  localparam int BW = `B4_BYTE_W;
  localparam int BYTES = DATA_W / BW;
  localparam int NB = `B4_BURST;
  localparam int WORDS = 1 << (ADDR_W + 2);

  // Whole array, one word per beat
  logic [DATA_W-1:0] mem [0:WORDS-1];

  logic rst_p;
  logic rst_n;
  logic dll_off;
  b4_pkg::b4_lat_e lat_q;
  logic [15:0] lock_cnt_q;

  logic rp1_q;
  logic rp2_q;
  logic [ADDR_W-1:0] ra1_q;
  logic [ADDR_W-1:0] ra2_q;
  logic wp1_q;
  logic wp2_q;
  logic wp3_q;
  logic [ADDR_W-1:0] wa1_q;
  logic [ADDR_W-1:0] wa2_q;
  logic [ADDR_W-1:0] wa3_q;

  logic [DATA_W-1:0] pd0_q;
  logic [DATA_W-1:0] pd1_q;
  logic [BYTES-1:0] pm0_q;
  logic [BYTES-1:0] pm1_q;
  logic [DATA_W-1:0] nd0_q;
  logic [DATA_W-1:0] nd1_q;
  logic [BYTES-1:0] nm0_q;
  logic [BYTES-1:0] nm1_q;

  logic fetch;
  logic [ADDR_W-1:0] faddr;
  logic [DATA_W-1:0] cbeat [NB];
  logic [BYTES-1:0] cmask [NB];
  logic [DATA_W-1:0] fword [NB];

  logic oph1_q;
  logic oph2_q;
  logic vpos_q;
  logic vneg_q;
  logic [DATA_W-1:0] qpos_q;
  logic [DATA_W-1:0] qneg_q;
  logic [DATA_W-1:0] rb1_q;
  logic [DATA_W-1:0] rb2_q;
  logic [DATA_W-1:0] rb3_q;
  logic [DATA_W-1:0] hold_q;

  // Replace enabled bytes of a word
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [BYTES-1:0] keep_n
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < BYTES; b++)
    begin
      if (!keep_n[b])
      begin
        res[b*BW +: BW] = new_w[b*BW +: BW];
      end
    end
    return res;
  endfunction

  // Reset and DLL pin brought onto the link clocks
  b4_sync #(.W(1)) u_rst_p (
    .clk_in(link.k_pos),
    .d_in(sys_rst_in),
    .q_out(rst_p)
  );

  b4_sync #(.W(1)) u_rst_n (
    .clk_in(link.k_neg),
    .d_in(sys_rst_in),
    .q_out(rst_n)
  );

  b4_sync #(.W(1)) u_dll (
    .clk_in(link.k_pos),
    .d_in(~link.dll_off_n),
    .q_out(dll_off)
  );

  // Latency mode and lock tracking
  always_ff @(posedge link.k_pos)
  begin
    if (rst_p || dll_off)
    begin
      lock_cnt_q <= 16'h0000;
    end
    else if (lock_cnt_q != 16'(LOCK_CYC))
    begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge link.k_pos)
  begin
    if (rst_p)
    begin
      lat_q <= b4_pkg::B4_LAT_FULL;
    end
    else
    begin
      lat_q <= dll_off ? b4_pkg::B4_LAT_ONE : b4_pkg::B4_LAT_FULL;
    end
  end

  assign dll_bypass_out = (lat_q == b4_pkg::B4_LAT_ONE);
  assign dll_locked_out = (lock_cnt_q == 16'(LOCK_CYC));

  // Command capture, positive clock only
  always_ff @(posedge link.k_pos)
  begin
    if (rst_p)
    begin
      rp1_q <= 1'b0;
      rp2_q <= 1'b0;
      wp1_q <= 1'b0;
      wp2_q <= 1'b0;
      wp3_q <= 1'b0;
    end
    else
    begin
      rp1_q <= ~link.read_select_n;
      rp2_q <= rp1_q;
      wp1_q <= ~link.write_select_n;
      wp2_q <= wp1_q;
      wp3_q <= wp2_q;
    end
  end

  always_ff @(posedge link.k_pos)
  begin
    if (!link.read_select_n)
    begin
      ra1_q <= link.sync_address_in;
    end
    if (!link.write_select_n)
    begin
      wa1_q <= link.sync_address_in;
    end
    ra2_q <= ra1_q;
    wa2_q <= wa1_q;
    wa3_q <= wa2_q;
  end

  // Write beats 1 and 3, then beats 2 and 4
  always_ff @(posedge link.k_pos)
  begin
    pd1_q <= link.d;
    pm1_q <= link.byte_write_n;
    pd0_q <= pd1_q;
    pm0_q <= pm1_q;
  end

  always_ff @(posedge link.k_neg)
  begin
    nd1_q <= link.d;
    nm1_q <= link.byte_write_n;
    nd0_q <= nd1_q;
    nm0_q <= nm1_q;
  end

  // Staged burst in beat order
  always_comb
  begin
    cbeat[0] = pd0_q;
    cbeat[1] = nd0_q;
    cbeat[2] = pd1_q;
    cbeat[3] = nd1_q;
    cmask[0] = pm0_q;
    cmask[1] = nm0_q;
    cmask[2] = pm1_q;
    cmask[3] = nm1_q;
  end

  // Commit all four beats of a write
  always_ff @(posedge link.k_pos)
  begin
    if (wp3_q)
    begin
      for (int i = 0; i < NB; i++)
      begin
        mem[{wa3_q, 2'(i)}] <= merge(mem[{wa3_q, 2'(i)}], cbeat[i], cmask[i]);
      end
    end
  end

  // Read fetch, with write buffer forwarding that only meets a following read in B4_LAT_FULL mode, never in B4_LAT_ONE
  assign fetch = (lat_q == b4_pkg::B4_LAT_ONE) ? rp1_q : rp2_q;
  assign faddr = (lat_q == b4_pkg::B4_LAT_ONE) ? ra1_q : ra2_q;

  always_comb
  begin
    for (int i = 0; i < NB; i++)
    begin
      if (wp3_q && (wa3_q == faddr))
      begin
        fword[i] = merge(mem[{faddr, 2'(i)}], cbeat[i], cmask[i]);
      end
      else
      begin
        fword[i] = mem[{faddr, 2'(i)}];
      end
    end
  end

  // Positive-edge output beats 1 and 3
  always_ff @(posedge link.k_pos)
  begin
    if (rst_p)
    begin
      oph1_q <= 1'b0;
      oph2_q <= 1'b0;
      vpos_q <= 1'b0;
    end
    else
    begin
      oph1_q <= fetch;
      oph2_q <= oph1_q;
      vpos_q <= fetch | oph1_q;
    end
  end

  always_ff @(posedge link.k_pos)
  begin
    if (rst_p)
    begin
      qpos_q <= '0;
    end
    else if (fetch)
    begin
      qpos_q <= fword[0];
      rb1_q <= fword[1];
      rb2_q <= fword[2];
      rb3_q <= fword[3];
    end
    else if (oph1_q)
    begin
      qpos_q <= rb2_q;
    end
  end

  // Negative-edge output beats 2 and 4
  always_ff @(posedge link.k_neg)
  begin
    if (rst_n)
    begin
      vneg_q <= 1'b0;
      qneg_q <= '0;
    end
    else
    begin
      vneg_q <= oph1_q | oph2_q;
      if (oph1_q)
      begin
        qneg_q <= rb1_q;
        hold_q <= rb3_q;
      end
      else if (oph2_q)
      begin
        qneg_q <= hold_q;
      end
    end
  end

  // DDR output and echo clocks on a port of their own
  assign link.q = link.k_pos ? qpos_q : qneg_q;
  assign link.read_valid_flag = link.k_pos ? vpos_q : vneg_q;
  assign link.echo_clock_pos = link.k_pos;
  assign link.echo_clock_neg = link.k_neg;
endmodule
`default_nettype wire

/* File: hw/b4_ctrl_end.sv */
// Controller end: makes the link clocks and issues burst commands
`timescale 1ns/10ps
`default_nettype none
`include "b4_cfg.svh"
module b4_ctrl_end #(
  parameter int DATA_W = `B4_DATA_W,
  parameter int ADDR_W = `B4_ADDR_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic dll_off_n_in,
  input wire logic rd_req_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic rd_ready_out,
  input wire logic wr_req_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [`B4_BURST*DATA_W-1:0] wr_data_in,
  input wire logic [`B4_BURST*(DATA_W/`B4_BYTE_W)-1:0] wr_byte_n_in,
  output logic wr_ready_out,
  output logic [`B4_BURST*DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  b4_if.ctrl link
);
  localparam int BYTES = DATA_W / `B4_BYTE_W;
  localparam int NB = `B4_BURST;

  logic kq;
  logic launch;
  logic rd_go;
  logic wr_go;
  b4_pkg::b4_slot_e slot_q;
  logic rsel_n_q;
  logic wsel_n_q;
  logic dll_n_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] pd_q [NB+1];
  logic [BYTES-1:0] pm_q [NB+1];
  logic [DATA_W-1:0] d_q;
  logic [BYTES-1:0] bw_q;
  logic [DATA_W:0] rx;
  logic [1:0] rcnt_q;

  // Link clock divider on the falling edge, half a cycle off the data
  always_ff @(negedge clk_in)
  begin
    if (sys_rst_in)
    begin
      kq <= 1'b0;
    end
    else
    begin
      kq <= ~kq;
    end
  end

  assign link.k_pos = kq;
  assign link.k_neg = ~kq;

  // Next falling edge raises the positive link clock
  assign launch = ~kq;
  assign rd_ready_out = launch & ~sys_rst_in & (slot_q == b4_pkg::B4_SLOT_RD);
  assign wr_ready_out = launch & ~sys_rst_in & (slot_q == b4_pkg::B4_SLOT_WR);
  assign rd_go = rd_req_in & rd_ready_out;
  assign wr_go = wr_req_in & wr_ready_out;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      slot_q <= b4_pkg::B4_SLOT_RD;
      rsel_n_q <= 1'b1;
      wsel_n_q <= 1'b1;
      addr_q <= '0;
      dll_n_q <= 1'b0;
    end
    else
    begin
      dll_n_q <= dll_off_n_in;
      if (launch)
      begin
        slot_q <= (slot_q == b4_pkg::B4_SLOT_RD) ? b4_pkg::B4_SLOT_WR : b4_pkg::B4_SLOT_RD;
        rsel_n_q <= ~rd_go;
        wsel_n_q <= ~wr_go;
        if (rd_go)
        begin
          addr_q <= rd_addr_in;
        end
        else if (wr_go)
        begin
          addr_q <= wr_addr_in;
        end
      end
    end
  end

  // Beat queue: one entry per half link cycle
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i <= NB; i++)
      begin
        pd_q[i] <= '0;
        pm_q[i] <= '1;
      end
      d_q <= '0;
      bw_q <= '1;
    end
    else
    begin
      d_q <= pd_q[0];
      bw_q <= pm_q[0];
      for (int i = 0; i < NB; i++)
      begin
        pd_q[i] <= pd_q[i+1];
        pm_q[i] <= pm_q[i+1];
      end
      pd_q[NB] <= '0;
      pm_q[NB] <= '1;
      if (wr_go)
      begin
        for (int i = 0; i < NB; i++)
        begin
          pd_q[i+1] <= wr_data_in[i*DATA_W +: DATA_W];
          pm_q[i+1] <= wr_byte_n_in[i*BYTES +: BYTES];
        end
      end
    end
  end

  assign link.read_select_n = rsel_n_q;
  assign link.write_select_n = wsel_n_q;
  assign link.sync_address_in = addr_q;
  assign link.d = d_q;
  assign link.byte_write_n = bw_q;
  assign link.dll_off_n = dll_n_q;

  // Returned beats and valid flag pass two flops
  b4_sync #(.W(DATA_W + 1)) u_rx (
    .clk_in(clk_in),
    .d_in({link.read_valid_flag, link.q}),
    .q_out(rx)
  );

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      rcnt_q <= 2'h0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end
    else
    begin
      rd_valid_out <= rx[DATA_W] && (rcnt_q == 2'h3);
      if (rx[DATA_W])
      begin
        rd_data_out[rcnt_q*DATA_W +: DATA_W] <= rx[DATA_W-1:0];
        rcnt_q <= rcnt_q + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/b4_link_sva.sv */
// Link protocol assertions between controller and memory ends
`timescale 1ns/10ps
`default_nettype none
`include "b4_cfg.svh"
module b4_link_sva #(
  parameter int DATA_W = `B4_DATA_W,
  parameter int ADDR_W = `B4_ADDR_W
) (
  input wire logic sys_rst_in,
  input wire logic k_pos,
  input wire logic k_neg,
  input wire logic read_select_n,
  input wire logic write_select_n,
  input wire logic [ADDR_W-1:0] sync_address_in,
  input wire logic [DATA_W-1:0] d,
  input wire logic [DATA_W/`B4_BYTE_W-1:0] byte_write_n,
  input wire logic [DATA_W-1:0] q,
  input wire logic echo_clock_pos,
  input wire logic echo_clock_neg,
  input wire logic read_valid_flag,
  input wire logic dll_off_n
);
  default clocking cb @(posedge k_pos);
  endclocking
  default disable iff (sys_rst_in);

  // Mode held steady around the command
  sequence s_rd_full;
    !read_select_n && dll_off_n && $past(dll_off_n, 4);
  endsequence
  sequence s_rd_one;
    !read_select_n && !dll_off_n && !$past(dll_off_n, 4);
  endsequence
  sequence s_beats;
    read_valid_flag ##1 read_valid_flag;
  endsequence

  property p_one_cmd;
    !(!read_select_n && !write_select_n);
  endproperty
  property p_rd_gap;
    !read_select_n |=> read_select_n;
  endproperty
  property p_wr_gap;
    !write_select_n |=> write_select_n;
  endproperty
  property p_lat_full;
    s_rd_full |-> ##3 s_beats;
  endproperty
  property p_lat_one;
    s_rd_one |-> ##2 s_beats;
  endproperty
  property p_vld_cause;
    $rose(read_valid_flag) |-> (dll_off_n ? !$past(read_select_n, 3) : !$past(read_select_n, 2));
  endproperty
  property p_echo_lo;
    !echo_clock_pos && echo_clock_neg;
  endproperty
  property p_echo_hi;
    @(posedge k_neg) echo_clock_pos && !echo_clock_neg;
  endproperty
  property p_idle_beats;
    $past(write_select_n) && $past(write_select_n, 2) |-> (&byte_write_n) && (d == '0);
  endproperty
  property p_burst;
    $fell(read_valid_flag) |-> $past(read_valid_flag, 2);
  endproperty

  a_one_cmd: assert property (p_one_cmd) else $error("read and write in one cycle");
  a_rd_gap: assert property (p_rd_gap) else $error("reads too close");
  a_wr_gap: assert property (p_wr_gap) else $error("writes too close");
  a_lat_full: assert property (p_lat_full) else $error("read latency wrong");
  a_lat_one: assert property (p_lat_one) else $error("bypass latency wrong");
  a_vld_cause: assert property (p_vld_cause) else $error("valid without read");
  a_echo_lo: assert property (p_echo_lo) else $error("echo clock out of step");
  a_echo_hi: assert property (p_echo_hi) else $error("echo clock out of step");
  a_burst: assert property (p_burst) else $error("burst shorter than four");
  a_idle_beats: assert property (p_idle_beats) else $error("write beat without write");
endmodule
`default_nettype wire

/* File: verif/burst4_ddr_sram_port_bench.sv */
// Bench joining controller and memory ends over the link
`timescale 1ns/10ps
`default_nettype none
`include "b4_cfg.svh"
module burst4_ddr_sram_port_bench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  // Device reset outlasts the controller's so the link clocks carry it in
  logic mem_rst = 1'b1;
  logic dll_off_n = 1'b1;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [17:0] rd_addr = 18'h0;
  logic [17:0] wr_addr = 18'h0;
  logic [143:0] wr_data = 144'h0;
  logic [15:0] wr_bn = 16'hFFFF;
  logic rd_rdy;
  logic wr_rdy;
  logic rd_vld;
  logic [143:0] rd_data;
  logic byp;
  logic locked;
  logic [143:0] mem [logic [17:0]];
  int fails = 0;
  int check_count = 0;

  b4_if b4_if_i ();
  b4_ctrl_end b4_ctrl_end_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .dll_off_n_in(dll_off_n),
    .rd_req_in(rd_req), .rd_addr_in(rd_addr), .rd_ready_out(rd_rdy), .wr_req_in(wr_req),
    .wr_addr_in(wr_addr), .wr_data_in(wr_data), .wr_byte_n_in(wr_bn), .wr_ready_out(wr_rdy),
    .rd_data_out(rd_data), .rd_valid_out(rd_vld), .link(b4_if_i));
  b4_mem_end #(.LOCK_CYC(8)) b4_mem_end_i (.link(b4_if_i), .sys_rst_in(mem_rst),
    .dll_bypass_out(byp), .dll_locked_out(locked));
  b4_link_sva #(.DATA_W(36), .ADDR_W(18)) b4_link_sva_i (.sys_rst_in(mem_rst),
    .k_pos(b4_if_i.k_pos), .k_neg(b4_if_i.k_neg), .read_select_n(b4_if_i.read_select_n),
    .write_select_n(b4_if_i.write_select_n), .sync_address_in(b4_if_i.sync_address_in),
    .d(b4_if_i.d), .byte_write_n(b4_if_i.byte_write_n), .q(b4_if_i.q),
    .echo_clock_pos(b4_if_i.echo_clock_pos), .echo_clock_neg(b4_if_i.echo_clock_neg),
    .read_valid_flag(b4_if_i.read_valid_flag), .dll_off_n(b4_if_i.dll_off_n));

  initial
  begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic end_of_test;
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp_data(input logic [143:0] got, input logic [143:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [143:0] pat(input logic [35:0] s);
    return {s + 36'h1, s ^ 36'hA5A5A5A5A, ~s, s};
  endfunction

  // Hold request until the edge where ready is high
  // Ready read at the rising edge, as the controller samples it
  task automatic take(input logic wr);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while ((wr ? wr_rdy : rd_rdy) !== 1'b1 && n < 16);
    cmp_bit(wr ? wr_rdy : rd_rdy, 1'b1);
    if (wr)
      wr_req <= 1'b0;
    else
      rd_req <= 1'b0;
  endtask

  task automatic do_wr(input logic [17:0] a, input logic [143:0] dv, input logic [15:0] bn);
    logic [143:0] w;
    w = mem.exists(a) ? mem[a] : 144'h0;
    for (int k = 0; k < 16; k++)
      if (!bn[k])
        w[k*9 +: 9] = dv[k*9 +: 9];
    mem[a] = w;
    @(posedge clk_in);
    wr_addr <= a;
    wr_data <= dv;
    wr_bn <= bn;
    wr_req <= 1'b1;
    take(1'b1);
  endtask

  task automatic do_rd(input logic [17:0] a);
    logic [143:0] exp;
    int n;
    exp = mem.exists(a) ? mem[a] : 144'h0;
    @(posedge clk_in);
    rd_addr <= a;
    rd_req <= 1'b1;
    take(1'b0);
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (rd_vld !== 1'b1 && n < 40);
    cmp_bit(rd_vld, 1'b1);
    cmp_data(rd_data, exp);
  endtask

  task automatic t_basic;
    do_wr(18'h00010, pat(36'h012345678), 16'h0000);
    do_wr(18'h3FFFF, pat(36'hFEDCBA987), 16'h0000);
    fork
      do_wr(18'h00050, pat(36'h0F0F0F0F0), 16'h0000);
      do_rd(18'h00010);
    join
    do_rd(18'h3FFFF);
    do_rd(18'h00050);
  endtask

  // Write followed at once by a read of it
  task automatic t_mask;
    logic [15:0] mk [4];
    mk = '{16'hFFFF, 16'h5AC3, 16'h0FF0, 16'hA55A};
    do_wr(18'h00020, pat(36'h111111111), 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      do_wr(18'h00020, pat(36'h222222222 * (i + 1)), mk[i]);
      do_rd(18'h00020);
    end
  endtask

  task automatic t_idle;
    logic seen;
    seen = 1'b0;
    repeat (40)
    begin
      @(negedge clk_in);
      seen = seen | rd_vld;
    end
    cmp_bit(seen, 1'b0);
  endtask

  task automatic t_dll;
    @(posedge clk_in);
    dll_off_n <= 1'b0;
    repeat (20) @(posedge clk_in);
    cmp_bit(byp, 1'b1);
    cmp_bit(locked, 1'b0);
    do_wr(18'h00060, pat(36'h987654321), 16'h0000);
    repeat (8) @(posedge clk_in);
    do_rd(18'h00060);
    @(posedge clk_in);
    dll_off_n <= 1'b1;
    repeat (40) @(posedge clk_in);
    cmp_bit(byp, 1'b0);
    cmp_bit(locked, 1'b1);
    do_rd(18'h00060);
  endtask

  initial
  begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    mem_rst <= 1'b0;
    repeat (40) @(posedge clk_in);
    cmp_bit(locked, 1'b1);
    t_basic();
    t_mask();
    t_idle();
    t_dll();
    end_of_test();
  end

  initial
  begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
